// file: rtl/crf_map.vh
`ifndef CRF_MAP_VH
`define CRF_MAP_VH

// Register select codes, shared by core ports and bus word index
`define CRF_SEL_W 5
`define CRF_SEL_D0 5'h00
`define CRF_SEL_D1 5'h01
`define CRF_SEL_D2 5'h02
`define CRF_SEL_D3 5'h03
`define CRF_SEL_D0L 5'h04
`define CRF_SEL_D0H 5'h05
`define CRF_SEL_D1L 5'h06
`define CRF_SEL_D1H 5'h07
`define CRF_SEL_DPL 5'h08
`define CRF_SEL_DPH 5'h09
`define CRF_SEL_ADR0 5'h0a
`define CRF_SEL_ADR1 5'h0b
`define CRF_SEL_AP 5'h0c
`define CRF_SEL_FRAME 5'h0d
`define CRF_SEL_STATIC 5'h0e
`define CRF_SEL_USER_SP 5'h0f
`define CRF_SEL_IRQ_SP 5'h10
`define CRF_SEL_SP 5'h11
`define CRF_SEL_VECT 5'h12
`define CRF_SEL_PROG 5'h13
`define CRF_SEL_FLAGS 5'h14

// Banked register slots
`define CRF_BANK_SLOTS 7
`define CRF_SLOT_D0 3'h0
`define CRF_SLOT_D1 3'h1
`define CRF_SLOT_D2 3'h2
`define CRF_SLOT_D3 3'h3
`define CRF_SLOT_ADR0 3'h4
`define CRF_SLOT_ADR1 3'h5
`define CRF_SLOT_FRAME 3'h6

// Flag register fields
`define CRF_FLAGS_W 11
`define CRF_FLAG_C 0
`define CRF_FLAG_D 1
`define CRF_FLAG_Z 2
`define CRF_FLAG_S 3
`define CRF_FLAG_B 4
`define CRF_FLAG_O 5
`define CRF_FLAG_I 6
`define CRF_FLAG_U 7

// Widths
`define CRF_PROG_W 20
`define CRF_VECT_W 20

// ALU operand sizes
`define CRF_SIZE_BYTE 2'h0
`define CRF_SIZE_WORD 2'h1
`define CRF_SIZE_LONG 2'h2

// Reset values
`define CRF_RST_WORD 16'h0000
`define CRF_RST_PROG 20'h00000
`define CRF_RST_VECT 20'h00000
`define CRF_RST_FLAGS 11'h000

// Bus word addressing
`define CRF_ADR_LSB 2
`define CRF_ADR_MSB 6

`endif

// file: rtl/crf_flag_unit.v
`timescale 1ns/1ps
`include "crf_map.vh"

// Zero and sign detection of an ALU result at its operand size
module crf_flag_unit (
  input wire [1:0] size_in,
  input wire [31:0] result_in,
  output reg zero_out,
  output reg sign_out
);

  always @* begin
    case (size_in)
      `CRF_SIZE_BYTE: begin
        zero_out = (result_in[7:0] == 8'h00); // RULE15
        sign_out = result_in[7]; // RULE16
      end
      `CRF_SIZE_LONG: begin
        zero_out = (result_in == 32'h0000_0000); // RULE15
        sign_out = result_in[31]; // RULE16
      end
      default: begin
        zero_out = (result_in[15:0] == 16'h0000); // RULE15
        sign_out = result_in[15]; // RULE16
      end
    endcase
  end

endmodule // crf_flag_unit

// file: rtl/crf_bank.v
`timescale 1ns/1ps
`include "crf_map.vh"

// Two banks of data, address and frame base registers
module crf_bank #(
  parameter SLOTS = `CRF_BANK_SLOTS
) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire bank_sel_in,
  input wire wr_a_en_in,
  input wire [2:0] wr_a_idx_in,
  input wire [1:0] wr_a_mask_in,
  input wire [15:0] wr_a_data_in,
  input wire wr_b_en_in,
  input wire [2:0] wr_b_idx_in,
  input wire [15:0] wr_b_data_in,
  output wire [16*SLOTS-1:0] regs_out
);

  reg [15:0] bank0_reg [0:SLOTS-1];
  reg [15:0] bank1_reg [0:SLOTS-1];

  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : g_slot
      wire hit_a;
      wire hit_b;
      wire [15:0] cur;
      wire [15:0] upd;
      assign hit_a = wr_a_en_in && (wr_a_idx_in == g);
      assign hit_b = wr_b_en_in && (wr_b_idx_in == g);
      assign cur = bank_sel_in ? bank1_reg[g] : bank0_reg[g]; // RULE17
      // Byte lanes keep the untouched half
      assign upd = hit_b ? wr_b_data_in :
        {wr_a_mask_in[1] ? wr_a_data_in[15:8] : cur[15:8],
         wr_a_mask_in[0] ? wr_a_data_in[7:0] : cur[7:0]}; // RULE19
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          bank0_reg[g] <= `CRF_RST_WORD;
          bank1_reg[g] <= `CRF_RST_WORD;
        end else if (hit_a || hit_b) begin
          if (bank_sel_in) begin
            bank1_reg[g] <= upd; // RULE17
          end else begin
            bank0_reg[g] <= upd;
          end
        end
      end
      assign regs_out[16*g+15:16*g] = cur;
    end
  endgenerate

endmodule // crf_bank

// file: rtl/crf_register_file.v
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "crf_map.vh"

// Overview of operation
// (RULE1) Four 16-bit general data registers
// (RULE2) First two data registers split into bytes
// (RULE3) Third/fourth pair above first/second as 32-bit
// (RULE4) Two 16-bit address registers, also operands
// (RULE5) Second address register is upper pair word
// (RULE6) 16-bit frame base register
// (RULE7) 20-bit interrupt vector table base
// (RULE8) 20-bit program counter, next instruction address
// (RULE9) User and interrupt stack pointers, 16 bits
// (RULE10) Stack select flag picks active pointer
// (RULE11) 16-bit static base register
// (RULE12) 11-bit flag register of processor state
// (RULE13) Carry flag captures ALU carry/borrow/shift-out
// (RULE14) Software keeps debug flag at zero
// (RULE15) Zero flag set on zero result
// (RULE16) Sign flag set on negative result
// (RULE17) Bank flag switches the banked register set
// (RULE18) Overflow flag set on overflow
// (RULE19) Byte writes keep other half; pairs together
module crf_register_file (
  input wire core_clk_in,
  input wire arst_n_in,
  // Wishbone classic slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [6:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire wb_ack_out,
  // Core operand read port
  input wire [4:0] core_rd_sel_in,
  output wire [31:0] core_rd_data_out,
  // Core write port
  input wire core_wr_en_in,
  input wire [4:0] core_wr_sel_in,
  input wire [31:0] core_wr_data_in,
  output wire core_ready_out,
  // ALU flag update
  input wire alu_update_in,
  input wire [1:0] alu_size_in,
  input wire [31:0] alu_result_in,
  input wire alu_carry_in,
  input wire alu_overflow_in,
  // Program counter advance in bytes
  input wire [2:0] pc_advance_in,
  // State seen by the core
  output wire [19:0] program_counter_out,
  output wire [10:0] cpu_flags_out,
  output wire [15:0] active_stack_pointer_out,
  output wire [15:0] frame_base_out,
  output wire [15:0] static_base_out,
  output wire [31:0] addr_pair_out,
  output wire [19:0] vector_table_base_out
);

  wire [111:0] bank_regs;
  wire [15:0] data_reg_0;
  wire [15:0] data_reg_1;
  wire [15:0] data_reg_2;
  wire [15:0] data_reg_3;
  wire [15:0] addr_reg_0;
  wire [15:0] addr_reg_1;
  wire [15:0] frame_base;

  reg [15:0] static_base_reg;
  reg [15:0] static_base_next;
  reg [19:0] vector_table_base_reg;
  reg [19:0] vector_table_base_next;
  reg [19:0] program_counter_reg;
  reg [19:0] program_counter_next;
  reg [15:0] user_stack_pointer_reg;
  reg [15:0] user_stack_pointer_next;
  reg [15:0] irq_stack_pointer_reg;
  reg [15:0] irq_stack_pointer_next;
  reg [10:0] cpu_flags_reg;
  reg [10:0] cpu_flags_next;
  reg ack_reg;
  reg [31:0] wb_dat_reg;
  reg [31:0] core_rd_reg;

  assign data_reg_0 = bank_regs[16*`CRF_SLOT_D0+15:16*`CRF_SLOT_D0];
  assign data_reg_1 = bank_regs[16*`CRF_SLOT_D1+15:16*`CRF_SLOT_D1];
  assign data_reg_2 = bank_regs[16*`CRF_SLOT_D2+15:16*`CRF_SLOT_D2];
  assign data_reg_3 = bank_regs[16*`CRF_SLOT_D3+15:16*`CRF_SLOT_D3];
  assign addr_reg_0 = bank_regs[16*`CRF_SLOT_ADR0+15:16*`CRF_SLOT_ADR0];
  assign addr_reg_1 = bank_regs[16*`CRF_SLOT_ADR1+15:16*`CRF_SLOT_ADR1];
  assign frame_base = bank_regs[16*`CRF_SLOT_FRAME+15:16*`CRF_SLOT_FRAME];

  // Active stack pointer by the stack select flag
  wire [15:0] active_sp;
  assign active_sp = cpu_flags_reg[`CRF_FLAG_U] ?
    user_stack_pointer_reg : irq_stack_pointer_reg; // RULE10

  // Read decode, shared by the core port and the bus
  function [31:0] reg_read;
    input [4:0] sel;
    begin
      case (sel)
        `CRF_SEL_D0: reg_read = {16'h0000, data_reg_0}; // RULE1
        `CRF_SEL_D1: reg_read = {16'h0000, data_reg_1};
        `CRF_SEL_D2: reg_read = {16'h0000, data_reg_2};
        `CRF_SEL_D3: reg_read = {16'h0000, data_reg_3};
        `CRF_SEL_D0L: reg_read = {24'h000000, data_reg_0[7:0]}; // RULE2
        `CRF_SEL_D0H: reg_read = {24'h000000, data_reg_0[15:8]};
        `CRF_SEL_D1L: reg_read = {24'h000000, data_reg_1[7:0]};
        `CRF_SEL_D1H: reg_read = {24'h000000, data_reg_1[15:8]};
        `CRF_SEL_DPL: reg_read = {data_reg_2, data_reg_0}; // RULE3
        `CRF_SEL_DPH: reg_read = {data_reg_3, data_reg_1}; // RULE3
        `CRF_SEL_ADR0: reg_read = {16'h0000, addr_reg_0}; // RULE4
        `CRF_SEL_ADR1: reg_read = {16'h0000, addr_reg_1};
        `CRF_SEL_AP: reg_read = {addr_reg_1, addr_reg_0}; // RULE5
        `CRF_SEL_FRAME: reg_read = {16'h0000, frame_base}; // RULE6
        `CRF_SEL_STATIC: reg_read = {16'h0000, static_base_reg}; // RULE11
        `CRF_SEL_USER_SP: reg_read = {16'h0000, user_stack_pointer_reg};
        `CRF_SEL_IRQ_SP: reg_read = {16'h0000, irq_stack_pointer_reg};
        `CRF_SEL_SP: reg_read = {16'h0000, active_sp}; // RULE10
        `CRF_SEL_VECT: reg_read = {12'h000, vector_table_base_reg};
        `CRF_SEL_PROG: reg_read = {12'h000, program_counter_reg};
        `CRF_SEL_FLAGS: reg_read = {21'h000000, cpu_flags_reg}; // RULE12
        default: reg_read = 32'h0000_0000;
      endcase
    end
  endfunction

  // Bus access sources
  wire [4:0] bus_idx;
  wire bus_req;
  wire bus_wr_fire;
  wire [31:0] bus_mask;
  wire [31:0] bus_merged;
  assign bus_idx = wb_adr_in[`CRF_ADR_MSB:`CRF_ADR_LSB];
  assign bus_req = wb_cyc_in && wb_stb_in;
  // Write lands on the edge where ack is seen high
  assign bus_wr_fire = bus_req && wb_we_in && ack_reg;
  assign bus_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
    {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign bus_merged = (reg_read(bus_idx) & ~bus_mask) |
    (wb_dat_in & bus_mask);

  // Bus write beats the core; the core holds while stalled
  assign core_ready_out = ~bus_wr_fire;

  wire wr_go;
  wire [4:0] wr_sel;
  wire [31:0] wr_val;
  assign wr_go = bus_wr_fire || core_wr_en_in;
  assign wr_sel = bus_wr_fire ? bus_idx : core_wr_sel_in;
  assign wr_val = bus_wr_fire ? bus_merged : core_wr_data_in;

  // Write decode into bank ports and plain registers
  reg wa_en;
  reg [2:0] wa_idx;
  reg [1:0] wa_mask;
  reg [15:0] wa_data;
  reg wb_en;
  reg [2:0] wb_idx;
  reg static_we;
  reg user_sp_we;
  reg irq_sp_we;
  reg vect_we;
  reg prog_we;
  reg flags_we;

  always @* begin
    wa_en = 1'b0;
    wa_idx = `CRF_SLOT_D0;
    wa_mask = 2'h3;
    wa_data = wr_val[15:0];
    wb_en = 1'b0;
    wb_idx = `CRF_SLOT_D2;
    static_we = 1'b0;
    user_sp_we = 1'b0;
    irq_sp_we = 1'b0;
    vect_we = 1'b0;
    prog_we = 1'b0;
    flags_we = 1'b0;
    if (wr_go) begin
      case (wr_sel)
        `CRF_SEL_D0, `CRF_SEL_D1, `CRF_SEL_D2, `CRF_SEL_D3: begin
          wa_en = 1'b1; // RULE1
          wa_idx = wr_sel[2:0];
        end
        `CRF_SEL_D0L, `CRF_SEL_D0H, `CRF_SEL_D1L, `CRF_SEL_D1H: begin
          wa_en = 1'b1; // RULE2
          wa_idx = wr_sel[1] ? `CRF_SLOT_D1 : `CRF_SLOT_D0;
          wa_mask = wr_sel[0] ? 2'h2 : 2'h1; // RULE19
          wa_data = {wr_val[7:0], wr_val[7:0]};
        end
        `CRF_SEL_DPL: begin
          wa_en = 1'b1; // RULE3
          wb_en = 1'b1; // RULE19
          wa_idx = `CRF_SLOT_D0;
          wb_idx = `CRF_SLOT_D2;
        end
        `CRF_SEL_DPH: begin
          wa_en = 1'b1; // RULE3
          wb_en = 1'b1; // RULE19
          wa_idx = `CRF_SLOT_D1;
          wb_idx = `CRF_SLOT_D3;
        end
        `CRF_SEL_ADR0: begin
          wa_en = 1'b1; // RULE4
          wa_idx = `CRF_SLOT_ADR0;
        end
        `CRF_SEL_ADR1: begin
          wa_en = 1'b1; // RULE4
          wa_idx = `CRF_SLOT_ADR1;
        end
        `CRF_SEL_AP: begin
          wa_en = 1'b1; // RULE5
          wb_en = 1'b1; // RULE19
          wa_idx = `CRF_SLOT_ADR0;
          wb_idx = `CRF_SLOT_ADR1;
        end
        `CRF_SEL_FRAME: begin
          wa_en = 1'b1; // RULE6
          wa_idx = `CRF_SLOT_FRAME;
        end
        `CRF_SEL_STATIC: static_we = 1'b1;
        `CRF_SEL_USER_SP: user_sp_we = 1'b1;
        `CRF_SEL_IRQ_SP: irq_sp_we = 1'b1;
        `CRF_SEL_SP: begin
          user_sp_we = cpu_flags_reg[`CRF_FLAG_U]; // RULE10
          irq_sp_we = ~cpu_flags_reg[`CRF_FLAG_U];
        end
        `CRF_SEL_VECT: vect_we = 1'b1;
        `CRF_SEL_PROG: prog_we = 1'b1;
        `CRF_SEL_FLAGS: flags_we = 1'b1;
        default: wa_en = 1'b0;
      endcase
    end
  end

  crf_bank #(
    .SLOTS(`CRF_BANK_SLOTS)
  ) u_bank (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .bank_sel_in(cpu_flags_reg[`CRF_FLAG_B]),
    .wr_a_en_in(wa_en),
    .wr_a_idx_in(wa_idx),
    .wr_a_mask_in(wa_mask),
    .wr_a_data_in(wa_data),
    .wr_b_en_in(wb_en),
    .wr_b_idx_in(wb_idx),
    .wr_b_data_in(wr_val[31:16]),
    .regs_out(bank_regs)
  );

  // ALU result flags
  wire alu_zero;
  wire alu_sign;
  wire alu_go;
  assign alu_go = alu_update_in && core_ready_out;

  crf_flag_unit u_flags (
    .size_in(alu_size_in),
    .result_in(alu_result_in),
    .zero_out(alu_zero),
    .sign_out(alu_sign)
  );

  // Next values of the plain registers
  always @* begin
    static_base_next = static_we ? wr_val[15:0] : static_base_reg; // RULE11
    user_stack_pointer_next = user_sp_we ? wr_val[15:0] :
      user_stack_pointer_reg; // RULE9
    irq_stack_pointer_next = irq_sp_we ? wr_val[15:0] :
      irq_stack_pointer_reg; // RULE9
    vector_table_base_next = vect_we ? wr_val[19:0] :
      vector_table_base_reg; // RULE7
    if (prog_we) begin
      program_counter_next = wr_val[19:0]; // RULE8
    end else if (core_ready_out) begin
      program_counter_next = program_counter_reg +
        {17'h00000, pc_advance_in}; // RULE8
    end else begin
      program_counter_next = program_counter_reg;
    end
    cpu_flags_next = flags_we ? wr_val[10:0] : cpu_flags_reg; // RULE12
    if (alu_go) begin
      cpu_flags_next[`CRF_FLAG_C] = alu_carry_in; // RULE13
      cpu_flags_next[`CRF_FLAG_Z] = alu_zero; // RULE15
      cpu_flags_next[`CRF_FLAG_S] = alu_sign; // RULE16
      cpu_flags_next[`CRF_FLAG_O] = alu_overflow_in; // RULE18
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      static_base_reg <= `CRF_RST_WORD;
      user_stack_pointer_reg <= `CRF_RST_WORD;
      irq_stack_pointer_reg <= `CRF_RST_WORD;
      vector_table_base_reg <= `CRF_RST_VECT;
      program_counter_reg <= `CRF_RST_PROG;
      cpu_flags_reg <= `CRF_RST_FLAGS;
    end else begin
      static_base_reg <= static_base_next;
      user_stack_pointer_reg <= user_stack_pointer_next;
      irq_stack_pointer_reg <= irq_stack_pointer_next;
      vector_table_base_reg <= vector_table_base_next;
      program_counter_reg <= program_counter_next;
      cpu_flags_reg <= cpu_flags_next;
    end
  end

  // Bus answer: ack one cycle after the request, then drop
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else if (bus_req && !ack_reg) begin
      ack_reg <= 1'b1;
      wb_dat_reg <= reg_read(bus_idx);
    end else begin
      ack_reg <= 1'b0;
    end
  end

  // Core operand read, one cycle latency
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_rd_reg <= 32'h0000_0000;
    end else begin
      core_rd_reg <= reg_read(core_rd_sel_in); // RULE4
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = wb_dat_reg;
  assign core_rd_data_out = core_rd_reg;
  assign program_counter_out = program_counter_reg; // RULE8
  assign cpu_flags_out = cpu_flags_reg;
  assign active_stack_pointer_out = active_sp; // RULE10
  assign frame_base_out = frame_base; // RULE6
  assign static_base_out = static_base_reg;
  assign addr_pair_out = {addr_reg_1, addr_reg_0}; // RULE5
  assign vector_table_base_out = vector_table_base_reg;

endmodule // crf_register_file

// file: verification/crf_register_file_asserts.sv
`timescale 1ns/1ps
module crf_rf_chk (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire core_ready_out,
  input wire core_wr_en_in,
  input wire [4:0] core_wr_sel_in,
  input wire [4:0] core_rd_sel_in,
  input wire [31:0] core_rd_data_out,
  input wire alu_update_in,
  input wire [1:0] alu_size_in,
  input wire [31:0] alu_result_in,
  input wire alu_carry_in,
  input wire alu_overflow_in,
  input wire [2:0] pc_advance_in,
  input wire [19:0] program_counter_out,
  input wire [10:0] cpu_flags_out,
  input wire [15:0] active_stack_pointer_out,
  input wire [31:0] addr_pair_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire alu_go = alu_update_in && core_ready_out;
  wire [4:0] sp_code = cpu_flags_out[7] ? 5'h0f : 5'h10;

  chk_zero_word:
    assert property (alu_go && alu_size_in == 2'h1 &&
      alu_result_in[15:0] == 16'h0000 |=> cpu_flags_out[2])
    else $error("zero flag missed");
  chk_sign_byte:
    assert property (alu_go && alu_size_in == 2'h0 |=>
      cpu_flags_out[3] == $past(alu_result_in[7]))
    else $error("sign flag wrong");
  chk_carry_cap:
    assert property (alu_go |=> cpu_flags_out[0] == $past(alu_carry_in))
    else $error("carry flag wrong");
  chk_ovf_cap:
    assert property (not (alu_go ##1
      cpu_flags_out[5] != $past(alu_overflow_in)))
    else $error("overflow flag wrong");
  chk_pc_step:
    assert property (core_ready_out &&
      !(core_wr_en_in && core_wr_sel_in == 5'h13) |=> program_counter_out
      == $past(program_counter_out) + {17'h0, $past(pc_advance_in)})
    else $error("program counter step wrong");
  chk_sp_pick:
    assert property (core_rd_sel_in == sp_code |=>
      core_rd_data_out == {16'h0000, $past(active_stack_pointer_out)})
    else $error("active stack pointer wrong");
  chk_pair_read:
    assert property (core_rd_sel_in == 5'h0c |=>
      core_rd_data_out == $past(addr_pair_out))
    else $error("address pair read wrong");
  chk_flag_width:
    assert property (core_rd_sel_in == 5'h14 |=> core_rd_data_out[31:11]
      == 21'h0 && core_rd_data_out[10:0] == $past(cpu_flags_out))
    else $error("flag register read wrong");
endmodule // crf_rf_chk

bind crf_register_file crf_rf_chk u_chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .core_ready_out(core_ready_out), .core_wr_en_in(core_wr_en_in),
  .core_wr_sel_in(core_wr_sel_in), .core_rd_sel_in(core_rd_sel_in),
  .core_rd_data_out(core_rd_data_out), .alu_update_in(alu_update_in),
  .alu_size_in(alu_size_in), .alu_result_in(alu_result_in),
  .alu_carry_in(alu_carry_in), .alu_overflow_in(alu_overflow_in),
  .pc_advance_in(pc_advance_in), .program_counter_out(program_counter_out),
  .cpu_flags_out(cpu_flags_out),
  .active_stack_pointer_out(active_stack_pointer_out),
  .addr_pair_out(addr_pair_out)
);

// file: verification/crf_core_model.sv
`timescale 1ns/1ps
module crf_core_model (
  input wire core_clk_in,
  input wire core_ready_in,
  output reg core_wr_en_out = 1'b0,
  output reg [4:0] core_wr_sel_out = 5'h00,
  output reg [31:0] core_wr_data_out = 32'h0,
  output reg alu_update_out = 1'b0,
  output reg [1:0] alu_size_out = 2'h0,
  output reg [31:0] alu_result_out = 32'h0,
  output reg alu_carry_out = 1'b0,
  output reg alu_overflow_out = 1'b0
);
  // Request held until an edge with ready high
  task hold;
    begin
      @(posedge core_clk_in);
      while (core_ready_in !== 1'b1) @(posedge core_clk_in);
    end
  endtask
  task write(input [4:0] sel, input [31:0] d);
    begin
      @(posedge core_clk_in);
      core_wr_en_out <= 1'b1;
      core_wr_sel_out <= sel;
      // Debug flag kept clear
      core_wr_data_out <= (sel == 5'h14) ? d & 32'hffff_fffd : d;
      hold;
      core_wr_en_out <= 1'b0;
      core_wr_data_out <= ~d;
    end
  endtask
  task alu(input [1:0] sz, input [31:0] res, input c, input o);
    begin
      @(posedge core_clk_in);
      alu_update_out <= 1'b1;
      alu_size_out <= sz;
      alu_result_out <= res;
      alu_carry_out <= c;
      alu_overflow_out <= o;
      hold;
      alu_update_out <= 1'b0;
      alu_result_out <= ~res;
    end
  endtask
endmodule // crf_core_model

// file: verification/crf_register_file_tb.sv
`timescale 1ns/1ps
module crf_register_file_tb;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [6:0] adr = 7'h00;
  reg [31:0] wdat = 32'h0;
  reg [4:0] rsel = 5'h00;
  reg [2:0] adv = 3'h0;
  reg [31:0] q;
  wire [31:0] rdat, rdata, wdata, ares, pair;
  wire [4:0] wsel;
  wire [1:0] asz;
  wire [19:0] prog, vbase;
  wire [10:0] flags;
  wire [15:0] asp, fbase, sbase;
  wire ack, rdy, wen, aup, ac, ao;
  integer failures = 0;
  integer checked = 0;
  integer cycles = 0;

  always #20 clk = ~clk;
  always @(posedge clk) rsel <= rsel + 5'h01;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      complete_run;
    end
  end

  crf_register_file uut (
    .core_clk_in(clk), .arst_n_in(arst_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .core_rd_sel_in(rsel), .core_rd_data_out(rdata),
    .core_wr_en_in(wen), .core_wr_sel_in(wsel), .core_wr_data_in(wdata),
    .core_ready_out(rdy), .alu_update_in(aup), .alu_size_in(asz),
    .alu_result_in(ares), .alu_carry_in(ac), .alu_overflow_in(ao),
    .pc_advance_in(adv), .program_counter_out(prog),
    .cpu_flags_out(flags), .active_stack_pointer_out(asp),
    .frame_base_out(fbase), .static_base_out(sbase), .addr_pair_out(pair),
    .vector_table_base_out(vbase)
  );
  crf_core_model core (
    .core_clk_in(clk), .core_ready_in(rdy), .core_wr_en_out(wen),
    .core_wr_sel_out(wsel), .core_wr_data_out(wdata),
    .alu_update_out(aup), .alu_size_out(asz), .alu_result_out(ares),
    .alu_carry_out(ac), .alu_overflow_out(ao)
  );

  task complete_run;
    begin
      if (failures == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string n, input [7:0] id, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s %h exp %h got %h", n, id, e, g);
      end
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task wb(input w, input [6:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      wdat <= ~d;
    end
  endtask
  task wr(input [4:0] r, input [31:0] d);
    wb(1'b1, {r, 2'b00}, d, q);
  endtask
  task rb(input [4:0] r, input [31:0] e);
    begin
      wb(1'b0, {r, 2'b00}, 32'h0, q);
      chk("bus read", {3'h0, r}, e, q);
    end
  endtask
  function [31:0] wmask(input [4:0] r);
    case (r)
      5'h12, 5'h13: wmask = 32'h000f_ffff;
      5'h14: wmask = 32'h0000_07ff;
      default: wmask = 32'h0000_ffff;
    endcase
  endfunction

  task t_data;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        core.write(i[4:0], 32'hffff_0000 | (32'h1111 * (i + 1)));
      for (i = 0; i < 4; i = i + 1)
        rb(i[4:0], 32'h1111 * (i + 1));
      wr(5'h05, 32'h0000_00ab);
      core.write(5'h06, 32'h0000_ff5c);
      rb(5'h00, 32'h0000_ab11);
      rb(5'h01, 32'h0000_225c);
      rb(5'h07, 32'h0000_0022);
      wr(5'h08, 32'h89ab_cdef);
      core.write(5'h09, 32'h1357_2468);
      rb(5'h02, 32'h0000_89ab);
      rb(5'h00, 32'h0000_cdef);
      rb(5'h09, 32'h1357_2468);
      wr(5'h1f, 32'hffff_ffff);
      rb(5'h1f, 32'h0);
    end
  endtask
  task t_addr;
    begin
      core.write(5'h0a, 32'h0000_a0a0);
      wr(5'h0b, 32'h0000_a1a1);
      rb(5'h0c, 32'ha1a1_a0a0);
      chk("addr pair", 8'h0c, 32'ha1a1_a0a0, pair);
      wr(5'h0c, 32'h0102_0304);
      rb(5'h0b, 32'h0000_0102);
    end
  endtask
  task t_width;
    integer i;
    begin
      for (i = 13; i < 21; i = i + 1) begin
        wr(i[4:0], ~32'h2);
        rb(i[4:0], ~32'h2 & wmask(i[4:0]));
      end
      chk("static base", 8'h0e, 32'h0000_fffd, {16'h0, sbase});
      chk("vector base", 8'h12, 32'h000f_fffd, {12'h0, vbase});
    end
  endtask
  task t_stack;
    begin
      wr(5'h14, 32'h0);
      wr(5'h0f, 32'h1111);
      wr(5'h10, 32'h2222);
      rb(5'h11, 32'h2222);
      wr(5'h14, 32'h0080);
      rb(5'h11, 32'h1111);
      chk("active sp", 8'h11, 32'h1111, {16'h0, asp});
    end
  endtask
  task t_bank;
    begin
      wr(5'h00, 32'haaaa);
      wr(5'h0d, 32'h0f0f);
      wr(5'h14, 32'h0010);
      wr(5'h00, 32'h5555);
      wr(5'h0d, 32'hf0f0);
      rb(5'h00, 32'h5555);
      wr(5'h14, 32'h0);
      rb(5'h00, 32'haaaa);
      chk("frame base", 8'h0d, 32'h0f0f, {16'h0, fbase});
    end
  endtask
  // Core write refused while a bus write lands, then retried
  task t_hold;
    begin
      fork
        wr(5'h02, 32'h0000_beef);
        begin
          @(posedge clk);
          core.write(5'h03, 32'h0000_cafe);
        end
      join
      rb(5'h02, 32'h0000_beef);
      rb(5'h03, 32'h0000_cafe);
    end
  endtask
  task t_pc;
    begin
      wr(5'h13, 32'h000f_fffe);
      @(posedge clk);
      adv <= 3'h2;
      repeat (5) @(posedge clk);
      adv <= 3'h0;
      rb(5'h13, 32'h0000_0008);
    end
  endtask
  task t_alu;
    integer i;
    reg [31:0] res;
    reg [5:0] e;
    reg [31:0] seen;
    for (i = 0; i < 6; i = i + 1) begin
      case (i)
        0: begin res = 32'h0000_0100; e = 6'h04; end
        1: begin res = 32'h0000_0080; e = 6'h09; end
        2: begin res = 32'h0001_0000; e = 6'h24; end
        3: begin res = 32'h0000_8000; e = 6'h29; end
        4: begin res = 32'h8000_0000; e = 6'h08; end
        default: begin res = 32'h0; e = 6'h05; end
      endcase
      core.alu(i[2:1], res, i[0], i[1]);
      @(negedge clk);
      seen = {21'h0, flags} & 32'h2d;
      chk("flags", i[7:0], {26'h0, e}, seen);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_data;
    t_addr;
    t_width;
    t_stack;
    t_bank;
    t_hold;
    t_pc;
    t_alu;
    complete_run;
  end
endmodule // crf_register_file_tb
